// *** bench/atpa_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module atpa_monitor (
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       connected,
	input wire logic       call_clear,
	input wire logic       data_state,
	input wire logic       in_ready,
	input wire logic       fwd_permit,
	input wire logic       out_valid,
	input wire logic       out_ready,
	input wire logic       out_last,
	input wire logic [7:0] out_data
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	chk_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_enter_data: assert property (connected && !data_state |-> ##[1:3] data_state)
		else $error("no data state");
	chk_leave_data: assert property (call_clear |-> ##[1:3] !data_state)
		else $error("data state kept");
	// Ready and data_state register from the same next state, so ready never lags it
	chk_ready_state: assert property (in_ready |-> data_state || $past(data_state))
		else $error("ready outside data");
	chk_fwd_permit: assert property ($rose(out_valid) |-> $past(fwd_permit))
		else $error("forward while blocked");
	chk_out_hold: assert property (out_valid && !out_ready && !call_clear |=>
		out_valid && $stable(out_data)) else $error("byte not held");
	chk_last_valid: assert property (out_last |-> out_valid)
		else $error("stray last");
	cover property ($rose(data_state));
	cover property (out_valid && out_last && out_ready);
	cover property (out_valid && !out_ready);
endmodule
`default_nettype wire

// *** bench/atpa_term_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module atpa_term_model #(
	parameter int BIT = 6
) (
	input  wire logic mclk,
	input  wire logic tx_o,
	output var  logic rx_i
);
	logic [8:0] got[$];
	logic [8:0] sh;
	initial rx_i = 1'b1;
	// Bit 8 is the stop level, so a low stop with zero data is a break
	task automatic send(input logic [8:0] c);
		for (int i = 0; i < 11; i++) begin
			@(posedge mclk);
			rx_i <= (i == 0) ? 1'b0 : ((i == 10) ? 1'b1 : c[i-1]);
			repeat (BIT - 1) @(posedge mclk);
		end
	endtask
	initial forever begin
		@(negedge tx_o);
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge mclk);
			sh[i] = tx_o;
		end
		got.push_back(sh);
		if (!tx_o) @(posedge tx_o);
	end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end
`define PULSE(s) begin @(posedge mclk); s <= 1'b1; @(posedge mclk); s <= 1'b0; end
module tb_top;
	import atpa_pkg::*;
	logic        mclk = 0, reset_n = 0, rx_i, tx_o, wb_ack_o, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]  wb_adr_i = 0, in_data = 0, out_data;
	logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
	logic        connected = 0, call_clear = 0, fwd_permit = 0, out_ready = 0, in_valid = 0;
	logic        vc_reset = 0, brk_in = 0, out_valid, out_last, in_ready, vc_reset_req, data_state;
	logic [1:0]  vc_cause = 0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic        cmd_done = 0, cmd_valid, intr_req, brk_ind;
	logic [7:0]  cmd_data, cmd_seen = 0;
	logic [8:0]  pkt[$];
	int          mismatches = 0, n_tests = 0, cycles = 0, n_vrst = 0, k = 0, n_intr = 0, n_bind = 0;
	logic [31:0] code[4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0105, 32'h0000_0005};
	logic [8:0]  svc[3] = '{{1'b1, SVC_REMOTE_CH}, {1'b1, SVC_PROC_CH}, {1'b1, SVC_CONG_CH}};
	atpa_term_model term_u (.mclk, .tx_o, .rx_i);
	atpa_top #(.PKT_LEN(4), .XOFF_M(1), .BIT_HI_CYC(6), .TICK_CYC(50)) dut_u (.mclk, .reset_n,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.rx_i, .tx_o, .connected, .call_clear, .cmd_done, .cmd_valid, .cmd_data, .fwd_permit,
		.out_valid, .out_data, .out_last, .out_ready, .in_valid, .in_data, .in_ready, .vc_reset,
		.vc_cause, .brk_in, .intr_req, .vc_reset_req, .brk_ind, .data_state);
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (vc_reset_req === 1'b1) n_vrst++;
		if (intr_req === 1'b1) n_intr++;
		if (brk_ind === 1'b1) n_bind++;
		if (cmd_valid === 1'b1) cmd_seen = cmd_data;
		if (out_valid === 1'b1 && out_ready === 1'b1) pkt.push_back({out_last, out_data});
		if (cycles == 10000) begin
			mismatches++;
			conclude();
		end
	end
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rx_is(input logic [8:0] e);
		wait (term_u.got.size() > k);
		`CHK("term char", e, term_u.got[k])
		k++;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		wb(1'b0, A_PARAM_A, 32'h0);
		`CHK("param a", 32'h0002_0014, rd)
		wb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped", 32'h0000_0000, rd)
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, A_PROFILE, code[i]);
			wb(1'b0, A_PARAM_A, 32'h0);
			`CHK("prof a", (i % 2) ? 32'h0002_0014 : 32'h0002_7E00, rd)
			wb(1'b0, A_PARAM_B, 32'h0);
			`CHK("prof b", (i % 2) ? 32'h0000_0000 : 32'h0000_000F, rd)
		end
		term_u.send(9'h155);
		repeat (70) @(posedge mclk);
		wb(1'b0, A_STATUS, 32'h0);
		`CHK("status", 10'h032, rd[9:0])
		wb(1'b1, A_PROFILE, 32'h0000_0001);
		`PULSE(connected)
		rx_is(9'h111);
		term_u.send(9'h141);
		term_u.send(9'h10D);
		repeat (200) @(posedge mclk);
		`CHK("held", 0, pkt.size())
		fwd_permit <= 1'b1;
		repeat (20) @(posedge mclk);
		out_ready <= 1'b1;
		wait (pkt.size() == 2);
		`CHK("fwd char", 9'h041, pkt[0])
		`CHK("fwd char", 9'h10D, pkt[1])
		wb(1'b1, A_PROFILE, 32'h0);
		for (int i = 0; i < 5; i++) term_u.send(9'h161 + i);
		wait (pkt.size() == 7);
		for (int i = 0; i < 5; i++) `CHK("full", {i > 2, 8'h61 + i[7:0]}, pkt[i + 2])
		@(posedge mclk);
		in_data  <= 8'h5A;
		in_valid <= 1'b1;
		do @(posedge mclk); while (in_ready !== 1'b1);
		in_valid <= 1'b0;
		rx_is(9'h15A);
		wb(1'b1, A_PARAM_B, 32'h0000_0001);
		term_u.send(9'h171);
		term_u.send(9'h110);
		term_u.send(9'h152);
		repeat (5) @(posedge mclk);
		`CHK("cmd fwd", 9'h171, pkt[7])
		`CHK("cmd char", 8'h52, cmd_seen)
		`CHK("cmd state", 1'b0, data_state)
		`PULSE(cmd_done)
		repeat (2) @(posedge mclk);
		`CHK("cmd back", 1'b1, data_state)
		wb(1'b1, A_PARAM_B, 32'h0000_0004);
		for (int i = 0; i < 3; i++) begin
			vc_cause <= i[1:0];
			`PULSE(vc_reset)
			rx_is(svc[i]);
		end
		wb(1'b1, A_PARAM_B, 32'h0);
		term_u.send(9'h000);
		repeat (70) @(posedge mclk);
		`CHK("reset req", 1, n_vrst)
		`PULSE(brk_in)
		rx_is(9'h000);
		wb(1'b1, A_PARAM_A, 32'h0015_FFFF, 4'h4);
		wb(1'b0, A_PARAM_A, 32'h0);
		`CHK("lanes", 32'h0015_0014, rd)
		term_u.send(9'h000);
		repeat (70) @(posedge mclk);
		`CHK("intr", 1, n_intr)
		`CHK("brk ind", 1, n_bind)
		wb(1'b0, A_PARAM_B, 32'h0);
		`CHK("discard", 32'h0000_0010, rd)
		`PULSE(call_clear)
		repeat (5) @(posedge mclk);
		`CHK("data state", 1'b0, data_state)
		conclude();
	end
endmodule
bind atpa_top atpa_monitor mon_u (.mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .connected,
	.call_clear, .data_state, .in_ready, .fwd_permit, .out_valid, .out_ready, .out_last, .out_data);
`default_nettype wire

// *** inc/atpa_pkg.sv ***
`default_nettype none
package atpa_pkg;
	localparam int unsigned CLK_HZ  = 20_000_000;
	localparam int unsigned RATE_LO = 110;
	localparam int unsigned RATE_MI = 200;
	localparam int unsigned RATE_HI = 300;
	localparam int unsigned BIT_LO_CYC = CLK_HZ / RATE_LO;
	localparam int unsigned BIT_MI_CYC = CLK_HZ / RATE_MI;
	localparam int unsigned BIT_HI_CYC = CLK_HZ / RATE_HI;
	localparam int unsigned TICK_PER_S = 20;
	localparam int unsigned TICK_CYC   = CLK_HZ / TICK_PER_S;
	localparam int          CNT_W      = 20;
	localparam int unsigned DEF_PKT_LEN = 16;
	localparam int unsigned DEF_XOFF_M  = 4;

	localparam logic [3:0] SPD_LO = 4'h0;
	localparam logic [3:0] SPD_MI = 4'h8;
	localparam logic [3:0] SPD_HI = 4'h2;

	localparam logic [4:0] STOP_BIT   = 5'h09;
	localparam logic [4:0] GUARD_BITS = 5'h0A;
	localparam logic [4:0] BRK_BITS   = 5'h14;

	localparam logic [7:0] CH_DLE  = 8'h10;
	localparam logic [7:0] CH_DC1  = 8'h11;
	localparam logic [7:0] CH_DC3  = 8'h13;
	localparam logic [7:0] CH_CR   = 8'h0D;
	localparam logic [7:0] CH_SP   = 8'h20;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_DEL  = 8'h7F;

	localparam logic [7:0] FWD_NONE = 8'h00;
	localparam logic [7:0] FWD_CR   = 8'h02;
	localparam logic [7:0] FWD_CTRL = 8'h7E;

	localparam logic [7:0] BRK_NONE  = 8'h00;
	localparam logic [7:0] BRK_INTR  = 8'h01;
	localparam logic [7:0] BRK_RESET = 8'h02;
	localparam logic [7:0] BRK_ESC   = 8'h08;
	localparam logic [7:0] BRK_DISC  = 8'h15;

	localparam logic [7:0] PROF_TRANSP = 8'h00;
	localparam logic [7:0] PROF_SIMPLE = 8'h01;
	localparam int         PROF_REQ_BIT = 8;

	localparam logic [7:0] TR_IDLE = 8'h14;
	localparam logic [7:0] SI_IDLE = 8'h00;

	localparam logic [1:0] CAUSE_REMOTE = 2'h0;
	localparam logic [1:0] CAUSE_PROC   = 2'h1;
	localparam logic [1:0] CAUSE_CONG   = 2'h2;
	localparam logic [7:0] SVC_REMOTE_CH = 8'h52;
	localparam logic [7:0] SVC_PROC_CH   = 8'h45;
	localparam logic [7:0] SVC_CONG_CH   = 8'h43;

	localparam logic [7:0] A_PARAM_A = 8'h00;
	localparam logic [7:0] A_PARAM_B = 8'h04;
	localparam logic [7:0] A_PROFILE = 8'h08;
	localparam logic [7:0] A_STATUS  = 8'h0C;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_DATA  = 4'b0010,
		ST_WAITC = 4'b0100,
		ST_CMD   = 4'b1000
	} atpa_state_t;
endpackage
`default_nettype wire

// *** logic/atpa_top.sv ***
// Notes on behaviour
// - Autodetected speed coded 0/8/2 for 110/200/300
// - Terminal flow control code 0 off, 1 on
// - Other profiles take the requested profile's defaults
// - Data transfer from connect until clear or escape
// - Recall set: DLE only via escape procedure
// - Character is bits between start and stop
// - Send at terminal rate with start, stop
// - Forward when data exceeds one packet
// - Forward after idle timer expires, flow permitting
// - Blocked: keep appending, X-OFF at M or fewer free
// - Forwarding character goes in packet, then forward
// - Break forwards unless break action is zero
// - First command character forwards pending packet
// - X-ON on entering data transfer if enabled
// - X-OFF at M free or when leaving
// - X-ON again once M+1 characters fit
// - Break action 2 resets the virtual call
// - Remote reset sends service signal if enabled
// - Cause: remote, procedure error or congestion
// - Break indication from packet side sends break
// - Idle timer in twentieths, zero disables
// - Forwarding set: none, CR, all controls plus DEL
// - Service signals suppressed at 0, sent at 1
// - Break action codes 0,1,2,8,21
`timescale 1ns/1ps
`default_nettype none
module atpa_top #(
	parameter int unsigned PKT_LEN    = atpa_pkg::DEF_PKT_LEN,
	parameter int unsigned XOFF_M     = atpa_pkg::DEF_XOFF_M,
	parameter int unsigned BIT_LO_CYC = atpa_pkg::BIT_LO_CYC,
	parameter int unsigned BIT_MI_CYC = atpa_pkg::BIT_MI_CYC,
	parameter int unsigned BIT_HI_CYC = atpa_pkg::BIT_HI_CYC,
	parameter int unsigned TICK_CYC   = atpa_pkg::TICK_CYC
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	input  wire logic        rx_i,
	output var  logic        tx_o,
	input  wire logic        connected,
	input  wire logic        call_clear,
	input  wire logic        cmd_done,
	output var  logic        cmd_valid,
	output var  logic [7:0]  cmd_data,
	input  wire logic        fwd_permit,
	output var  logic        out_valid,
	output var  logic [7:0]  out_data,
	output var  logic        out_last,
	input  wire logic        out_ready,
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_data,
	output var  logic        in_ready,
	input  wire logic        vc_reset,
	input  wire logic [1:0]  vc_cause,
	input  wire logic        brk_in,
	output var  logic        intr_req,
	output var  logic        vc_reset_req,
	output var  logic        brk_ind,
	output var  logic        data_state
);
	import atpa_pkg::*;

	localparam int IW = $clog2(PKT_LEN);
	localparam int CW = IW + 1;
	localparam int unsigned TH_HM = (BIT_HI_CYC + BIT_MI_CYC) / 2;
	localparam int unsigned TH_ML = (BIT_MI_CYC + BIT_LO_CYC) / 2;

	typedef struct packed {
		logic                     rx_s1;
		logic                     rx_s2;
		logic                     rx_d;
		atpa_state_t              state;
		logic [7:0]               p_idle;
		logic [7:0]               p_fwd;
		logic [7:0]               p_brk;
		logic                     p_recall;
		logic                     p_anc;
		logic                     p_svc;
		logic                     p_flow;
		logic                     discard;
		logic [7:0]               prof;
		logic                     spd_known;
		logic [3:0]               spd_code;
		logic                     meas;
		logic [CNT_W-1:0]         meas_cnt;
		logic                     rx_busy;
		logic                     rx_guard;
		logic [CNT_W-1:0]         rx_cnt;
		logic [4:0]               rx_bit;
		logic [7:0]               rx_sh;
		logic                     hold_v;
		logic [7:0]               hold_ch;
		logic [PKT_LEN-1:0][7:0]  buff;
		logic [CW-1:0]            count;
		logic [CW-1:0]            rd;
		logic                     fwd_req;
		logic                     drain;
		logic                     idle_arm;
		logic [CNT_W-1:0]         tick_cnt;
		logic [7:0]               idle_cnt;
		logic                     xoff_pend;
		logic                     xon_pend;
		logic                     xoff_sent;
		logic                     svc_pend;
		logic [7:0]               svc_ch;
		logic                     brk_pend;
		logic                     tx_paused;
		logic                     tx_busy;
		logic                     tx_brk;
		logic [CNT_W-1:0]         tx_cnt;
		logic [4:0]               tx_bit;
		logic [9:0]               tx_sh;
		logic                     tx_line;
		logic                     wb_ack;
		logic [31:0]              wb_dat;
		logic                     out_valid;
		logic                     out_last;
		logic [7:0]               out_data;
		logic                     in_ready;
		logic                     cmd_valid;
		logic [7:0]               cmd_data;
		logic                     intr_req;
		logic                     rst_req;
		logic                     brk_ind;
		logic                     dt;
	} atpa_st_t;

	atpa_st_t    st_reg;
	atpa_st_t    st_next;
	logic [1:0]  rst_sync_reg;
	logic        rst_n_s;

	function automatic logic [CNT_W-1:0] bit_cycles(input logic [3:0] code);
		case (code)
			SPD_HI: bit_cycles = CNT_W'(BIT_HI_CYC);
			SPD_MI: bit_cycles = CNT_W'(BIT_MI_CYC);
			default: bit_cycles = CNT_W'(BIT_LO_CYC);
		endcase
	endfunction

	function automatic logic is_fwd(input logic [7:0] ch, input logic [7:0] sel);
		case (sel)
			FWD_CR: is_fwd = (ch == CH_CR);
			FWD_CTRL: is_fwd = (ch < CH_SP) || (ch == CH_DEL);
			default: is_fwd = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] cause_char(input logic [1:0] cause);
		case (cause)
			CAUSE_REMOTE: cause_char = SVC_REMOTE_CH;
			CAUSE_PROC: cause_char = SVC_PROC_CH;
			default: cause_char = SVC_CONG_CH;
		endcase
	endfunction

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n_s = rst_sync_reg[1];

	always_comb begin
		logic [CNT_W-1:0] bitc;
		logic [CW-1:0]    free;
		logic             rx_ev;
		logic             brk_ev;
		logic             go_dt;
		logic             go_wait;
		logic             start;
		logic             tx_go;
		logic [7:0]       tx_ch;
		logic             wr;
		logic [7:0]       ch;
		st_next = st_reg;
		bitc = bit_cycles(st_reg.spd_code);
		free = CW'(PKT_LEN) - st_reg.count;
		ch = st_reg.rx_sh;
		rx_ev = 1'b0;
		brk_ev = 1'b0;
		go_dt = 1'b0;
		go_wait = 1'b0;
		tx_go = 1'b0;
		tx_ch = 8'h00;
		start = 1'b0;
		wr = 1'b0;
		st_next.rx_s1 = rx_i;
		st_next.rx_s2 = st_reg.rx_s1;
		st_next.rx_d = st_reg.rx_s2;
		st_next.cmd_valid = 1'b0;
		st_next.intr_req = 1'b0;
		st_next.rst_req = 1'b0;
		st_next.brk_ind = 1'b0;

		// Register bus: ack one cycle after request, write lands at the ack edge
		st_next.wb_ack = wb_cyc_i && wb_stb_i && !st_reg.wb_ack;
		wr = st_reg.wb_ack && wb_cyc_i && wb_stb_i && wb_we_i;
		case ({wb_adr_i[7:2], 2'b00})
			A_PARAM_A: st_next.wb_dat = {8'h00, st_reg.p_brk, st_reg.p_fwd, st_reg.p_idle};
			A_PARAM_B: st_next.wb_dat = {27'h000_0000, st_reg.discard, st_reg.p_flow,
				st_reg.p_svc, st_reg.p_anc, st_reg.p_recall};
			A_PROFILE: st_next.wb_dat = {24'h00_0000, st_reg.prof};
			A_STATUS: st_next.wb_dat = {16'h0000, 5'(st_reg.count), st_reg.xoff_sent,
				st_reg.tx_paused, st_reg.state, st_reg.spd_known, st_reg.spd_code};
			default: st_next.wb_dat = 32'h0000_0000;
		endcase
		if (wr && {wb_adr_i[7:2], 2'b00} == A_PARAM_A) begin
			if (wb_sel_i[0]) st_next.p_idle = wb_dat_i[7:0];
			if (wb_sel_i[1]) st_next.p_fwd = wb_dat_i[15:8];
			if (wb_sel_i[2]) st_next.p_brk = wb_dat_i[23:16];
		end
		if (wr && wb_sel_i[0] && {wb_adr_i[7:2], 2'b00} == A_PARAM_B) begin
			st_next.p_recall = wb_dat_i[0];
			st_next.p_anc = wb_dat_i[1];
			st_next.p_svc = wb_dat_i[2];
			st_next.p_flow = wb_dat_i[3];
			st_next.discard = wb_dat_i[4];
		end
		if (wr && wb_sel_i[0] && {wb_adr_i[7:2], 2'b00} == A_PROFILE) begin
			st_next.prof = wb_dat_i[7:0];
			// Speed is never loaded from a profile: it stays as detected
			if (wb_dat_i[7:0] == PROF_SIMPLE ||
			    (wb_dat_i[7:0] != PROF_TRANSP && wb_dat_i[PROF_REQ_BIT])) begin
				st_next.p_recall = 1'b1;
				st_next.p_fwd = FWD_CTRL;
				st_next.p_idle = SI_IDLE;
				st_next.p_anc = 1'b1;
				st_next.p_svc = 1'b1;
				st_next.p_brk = BRK_RESET;
				st_next.p_flow = 1'b1;
			end else begin
				st_next.p_recall = 1'b0;
				st_next.p_fwd = FWD_NONE;
				st_next.p_idle = TR_IDLE;
				st_next.p_anc = 1'b0;
				st_next.p_svc = 1'b0;
				st_next.p_brk = BRK_RESET;
				st_next.p_flow = 1'b0;
			end
		end

		// Receiver: first start bit measures the speed, then framed characters
		if (!st_reg.spd_known) begin
			if (st_reg.meas) begin
				if (st_reg.rx_s2) begin
					st_next.meas = 1'b0;
					st_next.spd_known = 1'b1;
					st_next.spd_code = (st_reg.meas_cnt < CNT_W'(TH_HM)) ? SPD_HI :
						(st_reg.meas_cnt < CNT_W'(TH_ML)) ? SPD_MI : SPD_LO;
					st_next.rx_guard = 1'b1;
					st_next.rx_cnt = '0;
					st_next.rx_bit = '0;
				end else if (st_reg.meas_cnt != '1) begin
					st_next.meas_cnt = st_reg.meas_cnt + 1'b1;
				end
			end else if (!st_reg.rx_s2 && st_reg.rx_d) begin
				st_next.meas = 1'b1;
				st_next.meas_cnt = '0;
			end
		end else if (st_reg.rx_guard) begin
			// Line must rest at mark for a whole character before the next start bit
			if (!st_reg.rx_s2) begin
				st_next.rx_cnt = '0;
				st_next.rx_bit = '0;
			end else if (st_reg.rx_cnt == bitc - 1'b1) begin
				st_next.rx_cnt = '0;
				st_next.rx_bit = st_reg.rx_bit + 1'b1;
				if (st_reg.rx_bit == GUARD_BITS - 1'b1)
					st_next.rx_guard = 1'b0;
			end else begin
				st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
			end
		end else if (st_reg.rx_busy) begin
			if (st_reg.rx_cnt != '0) begin
				st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
			end else begin
				st_next.rx_cnt = bitc - 1'b1;
				st_next.rx_bit = st_reg.rx_bit + 1'b1;
				if (st_reg.rx_bit == 5'h00) begin
					if (st_reg.rx_s2)
						st_next.rx_busy = 1'b0;
				end else if (st_reg.rx_bit != STOP_BIT) begin
					st_next.rx_sh = {st_reg.rx_s2, st_reg.rx_sh[7:1]};
				end else begin
					st_next.rx_busy = 1'b0;
					if (st_reg.rx_s2) begin
						rx_ev = 1'b1;
					end else if (st_reg.rx_sh == 8'h00) begin
						brk_ev = 1'b1;
						st_next.rx_guard = 1'b1;
						st_next.rx_cnt = '0;
						st_next.rx_bit = '0;
					end
				end
			end
		end else if (!st_reg.rx_s2 && st_reg.rx_d) begin
			st_next.rx_busy = 1'b1;
			st_next.rx_cnt = bitc >> 1;
			st_next.rx_bit = '0;
		end

		// Packet assembly; a start in this cycle blocks appends so no char is lost
		start = !st_reg.drain && st_reg.fwd_req && st_reg.count != '0 && fwd_permit;
		if (st_reg.hold_v && !st_reg.drain && !start) begin
			if (st_reg.count == CW'(PKT_LEN)) begin
				st_next.fwd_req = 1'b1;
			end else begin
				st_next.buff[st_reg.count[IW-1:0]] = st_reg.hold_ch;
				st_next.count = st_reg.count + 1'b1;
				st_next.hold_v = 1'b0;
				if (is_fwd(st_reg.hold_ch, st_reg.p_fwd))
					st_next.fwd_req = 1'b1;
			end
		end
		if (st_reg.drain) begin
			if (out_ready) begin
				if (st_reg.out_last) begin
					st_next.drain = 1'b0;
					st_next.out_valid = 1'b0;
					st_next.out_last = 1'b0;
					st_next.count = '0;
				end else begin
					st_next.rd = st_reg.rd + 1'b1;
					st_next.out_data = st_reg.buff[st_next.rd[IW-1:0]];
					st_next.out_last = (st_reg.rd + 2'd2 == st_reg.count);
				end
			end
		end else if (start) begin
			st_next.fwd_req = 1'b0;
			st_next.drain = 1'b1;
			st_next.rd = '0;
			st_next.out_valid = 1'b1;
			st_next.out_data = st_reg.buff[0];
			st_next.out_last = (st_reg.count == CW'(1));
		end else if (st_reg.fwd_req && st_reg.count == '0 && !st_reg.hold_v) begin
			st_next.fwd_req = 1'b0;
		end

		// Idle timer in twentieths of a second
		if (st_reg.state == ST_DATA && st_reg.idle_arm && st_reg.p_idle != 8'h00) begin
			if (st_reg.tick_cnt == CNT_W'(TICK_CYC - 1)) begin
				st_next.tick_cnt = '0;
				st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
				if (st_reg.idle_cnt == st_reg.p_idle - 1'b1) begin
					st_next.fwd_req = 1'b1;
					st_next.idle_arm = 1'b0;
				end
			end else begin
				st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
			end
		end

		// Characters from the terminal by interface state
		if (rx_ev && st_reg.p_flow && (ch == CH_DC1 || ch == CH_DC3)) begin
			st_next.tx_paused = (ch == CH_DC3);
		end else if (rx_ev) begin
			case (st_reg.state)
				ST_DATA: begin
					st_next.idle_arm = (st_reg.p_idle != 8'h00);
					st_next.idle_cnt = 8'h00;
					st_next.tick_cnt = '0;
					if (st_reg.p_recall && ch == CH_DLE) begin
						go_wait = 1'b1;
					end else begin
						if (st_reg.p_anc && !st_reg.xoff_sent && free <= CW'(XOFF_M)) begin
							st_next.xoff_pend = 1'b1;
							st_next.xoff_sent = 1'b1;
						end
						// Overrun while the hold byte is busy drops the character
						if (!st_next.hold_v) begin
							st_next.hold_v = 1'b1;
							st_next.hold_ch = ch;
						end
					end
				end
				ST_WAITC: begin
					if (ch == CH_DLE) begin
						go_dt = 1'b1;
						st_next.hold_v = 1'b1;
						st_next.hold_ch = ch;
					end else if (ch == CH_CR || ch == CH_PLUS) begin
						go_dt = 1'b1;
					end else if (ch > CH_SP && ch < CH_DEL) begin
						st_next.state = ST_CMD;
						st_next.fwd_req = 1'b1;
						st_next.cmd_valid = 1'b1;
						st_next.cmd_data = ch;
					end
				end
				ST_CMD: begin
					st_next.cmd_valid = 1'b1;
					st_next.cmd_data = ch;
				end
				default: ;
			endcase
		end

		if (brk_ev && st_reg.state == ST_DATA && st_reg.p_brk != BRK_NONE) begin
			st_next.fwd_req = 1'b1;
			case (st_reg.p_brk)
				BRK_INTR: st_next.intr_req = 1'b1;
				BRK_RESET: st_next.rst_req = 1'b1;
				BRK_ESC: go_wait = 1'b1;
				BRK_DISC: begin
					st_next.discard = 1'b1;
					st_next.intr_req = 1'b1;
					st_next.brk_ind = 1'b1;
				end
				default: ;
			endcase
		end

		if (st_reg.state == ST_IDLE && connected)
			go_dt = 1'b1;
		if (st_reg.state == ST_CMD && cmd_done)
			go_dt = 1'b1;
		if (go_wait)
			st_next.state = ST_WAITC;
		if (go_dt) begin
			st_next.state = ST_DATA;
			st_next.xoff_sent = 1'b0;
			st_next.xon_pend = st_reg.p_anc;
		end
		if ((go_wait || (call_clear && st_reg.state != ST_IDLE)) && st_reg.p_anc) begin
			st_next.xoff_pend = 1'b1;
			st_next.xoff_sent = 1'b1;
		end
		if (call_clear && st_reg.state != ST_IDLE) begin
			st_next.state = ST_IDLE;
			st_next.count = '0;
			st_next.hold_v = 1'b0;
			st_next.fwd_req = 1'b0;
			st_next.drain = 1'b0;
			st_next.out_valid = 1'b0;
			st_next.out_last = 1'b0;
		end
		if (st_reg.state == ST_DATA && st_reg.xoff_sent && !st_reg.xoff_pend &&
		    free > CW'(XOFF_M)) begin
			st_next.xon_pend = 1'b1;
			st_next.xoff_sent = 1'b0;
		end
		if (vc_reset && st_reg.p_svc) begin
			st_next.svc_pend = 1'b1;
			st_next.svc_ch = cause_char(vc_cause);
		end
		if (brk_in)
			st_next.brk_pend = 1'b1;

		// Transmitter; an accepted data byte beats flow characters beat service signals beat break
		if (st_reg.tx_busy) begin
			if (st_reg.tx_cnt != bitc - 1'b1) begin
				st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
			end else begin
				st_next.tx_cnt = '0;
				st_next.tx_bit = st_reg.tx_bit + 1'b1;
				if (st_reg.tx_brk) begin
					if (st_reg.tx_bit == BRK_BITS - 1'b1) begin
						st_next.tx_busy = 1'b0;
						st_next.tx_line = 1'b1;
					end
				end else begin
					st_next.tx_sh = {1'b1, st_reg.tx_sh[9:1]};
					st_next.tx_line = st_reg.tx_sh[1];
					if (st_reg.tx_bit == STOP_BIT)
						st_next.tx_busy = 1'b0;
				end
			end
		end else if (in_valid && st_reg.in_ready) begin
			tx_go = !st_reg.discard;
			tx_ch = in_data;
		end else if (st_reg.xoff_pend) begin
			tx_go = 1'b1;
			tx_ch = CH_DC3;
			st_next.xoff_pend = 1'b0;
		end else if (st_reg.xon_pend) begin
			tx_go = 1'b1;
			tx_ch = CH_DC1;
			st_next.xon_pend = 1'b0;
		end else if (st_reg.svc_pend) begin
			tx_go = 1'b1;
			tx_ch = st_reg.svc_ch;
			st_next.svc_pend = 1'b0;
		end else if (st_reg.brk_pend) begin
			st_next.brk_pend = 1'b0;
			st_next.tx_busy = 1'b1;
			st_next.tx_brk = 1'b1;
			st_next.tx_line = 1'b0;
			st_next.tx_cnt = '0;
			st_next.tx_bit = '0;
		end
		if (tx_go) begin
			st_next.tx_busy = 1'b1;
			st_next.tx_brk = 1'b0;
			st_next.tx_sh = {1'b1, tx_ch, 1'b0};
			st_next.tx_line = 1'b0;
			st_next.tx_cnt = '0;
			st_next.tx_bit = '0;
		end
		// Delivery waits outside data transfer and while the terminal paused us
		st_next.in_ready = !st_next.tx_busy && !tx_go && st_next.state == ST_DATA &&
			!st_next.tx_paused && !st_next.xoff_pend && !st_next.xon_pend &&
			!st_next.svc_pend && !st_next.brk_pend && !(in_valid && st_reg.in_ready);
		st_next.dt = (st_next.state == ST_DATA);
	end

	always_ff @(posedge mclk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_reg <= '0;
			st_reg.state <= ST_IDLE;
			st_reg.tx_line <= 1'b1;
			st_reg.p_idle <= TR_IDLE;
			st_reg.p_brk <= BRK_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o = st_reg.wb_dat;
	assign wb_ack_o = st_reg.wb_ack;
	assign tx_o = st_reg.tx_line;
	assign cmd_valid = st_reg.cmd_valid;
	assign cmd_data = st_reg.cmd_data;
	assign out_valid = st_reg.out_valid;
	assign out_data = st_reg.out_data;
	assign out_last = st_reg.out_last;
	assign in_ready = st_reg.in_ready;
	assign intr_req = st_reg.intr_req;
	assign vc_reset_req = st_reg.rst_req;
	assign brk_ind = st_reg.brk_ind;
	assign data_state = st_reg.dt;
endmodule
`default_nettype wire
